// ===== pkg/lcc_pkg.sv
// constants and types shared by the logic cluster design
package lcc_pkg;

   localparam int NCELL = 10;
   localparam int NCTL  = 10;
   localparam int NROW  = 6;
   localparam int NLOC  = 30;
   localparam int NSRC  = NLOC + NROW;

   // register byte offsets
   localparam logic [7:0] CFG_A_BASE = 8'h00;
   localparam logic [7:0] CFG_B_BASE = 8'h40;
   localparam logic [7:0] SRC_LO_OFF = 8'h80;
   localparam logic [7:0] SRC_HI_OFF = 8'h84;
   localparam logic [7:0] MISC_OFF   = 8'h88;
   localparam logic [7:0] STAT_OFF   = 8'h8c;

   // reset values
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] SRC_RESET = 32'h3fff_ffff;
   localparam logic [31:0] MISC_RESET = 32'h0000_0000;
   localparam logic [5:0]  SRC_NONE  = 6'h3f;

   // control signal positions inside the source selects
   localparam int CTL_CLK1    = 0;
   localparam int CTL_CLK2    = 1;
   localparam int CTL_ENA1    = 2;
   localparam int CTL_ENA2    = 3;
   localparam int CTL_ACLR1   = 4;
   localparam int CTL_ACLR2   = 5;
   localparam int CTL_SCLR    = 6;
   localparam int CTL_ALOAD   = 7;
   localparam int CTL_SLOAD   = 8;
   localparam int CTL_ADDNSUB = 9;
   localparam int SRC_PER_REG = 5;

   typedef enum logic [1:0] {
      LCC_FF_D,
      LCC_FF_T,
      LCC_FF_JK,
      LCC_FF_SR
   } lcc_ff_e;

   typedef struct packed {
      logic [4:0]  spare;
      logic        arith;
      logic        reg_chain;
      logic        lut_chain;
      logic        pack_fb;
      logic [2:0]  out_reg;
      logic        clr_sel;
      logic        clk_sel;
      lcc_ff_e     ff_mode;
      logic [15:0] lut_mask;
   } lcc_cell_cfg_s;

   typedef struct packed {
      logic [7:0]      spare;
      logic [3:0]      use_local;
      logic [3:0][4:0] local_sel;
   } lcc_cell_src_s;

   typedef struct packed {
      logic [28:0] spare;
      logic        devclr_en;
      logic        fall2;
      logic        fall1;
   } lcc_misc_s;

   typedef struct packed {
      logic            dev_clr_n;
      logic [5:0]      row;
      logic [9:0]      left;
      logic [9:0]      right;
      logic [9:0][3:0] data;
   } lcc_pins_s;

endpackage

// ===== core/lcc_cluster.sv
// ten-cell logic cluster with shared controls and wishbone configuration
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - cells are grouped ten to a cluster sharing routing and controls
// - each cell has a four-input table realising any four-variable function
// - cluster offers ten controls: two clocks, two enables, two asynchronous clears, plus four more
// - each cluster clock is paired with its own clock enable
// - using both edges of one clock consumes both cluster clocks
// - dropping a clock enable stops that clock; registers hold
// - asynchronous load with high data acts as preset to one
// - cell register works as D, T, JK or SR flip-flop
// - register has data, load data, clock, enable, clear, load inputs
// - asynchronous load value comes from the fourth data input
// - combinational use bypasses the register to the cell outputs
// - three outputs per cell, each picks table result or register
// - table and register may serve unrelated functions on two outputs
// - packing mode feeds register output back into the same table
// - table output chains to the next cell for wider functions
// - register output chains to next register forming a shift chain
// - add/subtract select picks A+B or A-B for the cluster
// - subtraction inverts B bits and forces lowest carry in to one
// - local and direct links reach thirty cells; neighbours drive local lines
// - controls are derived from six row clocks and local routing
// - asynchronous clear beats asynchronous load when both asserted
// - enabled device-wide clear resets every register, overriding all
// - synchronous clear and load act on every register of the cluster
module lcc_cluster #(
   parameter int ADR_W = 8
) (
   input  wire logic                 mclk_in,
   input  wire logic                 reset_in,
   input  wire logic                 wb_cyc_in,
   input  wire logic                 wb_stb_in,
   input  wire logic                 wb_we_in,
   input  wire logic [ADR_W-1:0]     wb_adr_in,
   input  wire logic [3:0]           wb_sel_in,
   input  wire logic [31:0]          wb_dat_in,
   output var  logic [31:0]          wb_dat_out,
   output var  logic                 wb_ack_out,
   input  wire logic [5:0]           row_clock_in,
   input  wire logic [9:0]           left_link_in,
   input  wire logic [9:0]           right_link_in,
   input  wire logic [9:0][3:0]      routing_data_in,
   input  wire logic                 device_wide_clear_n_in,
   output var  logic [9:0][2:0]      cell_out_out,
   output var  logic                 lut_chain_out,
   output var  logic                 reg_chain_out,
   output var  logic                 carry_out
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks

   if (ADR_W < 8) begin : g_adr_check
      $error("lcc_cluster: ADR_W must be at least 8");
   end

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      lcc_pkg::lcc_pins_s        sync1;
      lcc_pkg::lcc_pins_s        sync2;
      logic [9:0][31:0]          cfg_a;
      logic [9:0][31:0]          cfg_b;
      logic [31:0]               src_lo;
      logic [31:0]               src_hi;
      logic [31:0]               misc;
      logic [1:0]                clk_prev;
      logic [9:0]                q;
      logic [9:0][2:0]           outs;
      logic                      lut_chain;
      logic                      carry;
      logic                      ack;
      logic [31:0]               dat;
   } lcc_state_s;

   lcc_state_s s_q;
   lcc_state_s s_d;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wr,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wr[8*b +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      lcc_pkg::lcc_pins_s     p;
      lcc_pkg::lcc_cell_cfg_s cfg;
      lcc_pkg::lcc_cell_src_s csr;
      lcc_pkg::lcc_misc_s     misc;
      logic [59:0]            srcs;
      logic [29:0]            loc;
      logic [35:0]            srcv;
      logic [9:0]             ctl;
      logic [9:0]             none;
      logic [5:0]             sel;
      logic                   ena1;
      logic                   ena2;
      logic                   tick1;
      logic                   tick2;
      logic                   carry;
      logic                   lchain;
      logic                   rchain;
      logic [3:0]             din;
      logic [3:0]             lin;
      logic                   lut;
      logic                   b_op;
      logic                   sum;
      logic                   res;
      logic                   dsrc;
      logic                   nq;
      logic                   tick;
      logic                   aclr;
      logic [5:0]             widx;
      logic                   hit;
      logic [31:0]            rd;

      s_d = s_q;
      p = s_q.sync2;
      misc = lcc_pkg::lcc_misc_s'(s_q.misc);
      // locals start defined so no path can leave a latch behind
      cfg    = '0;
      csr    = '0;
      srcs   = 60'h0;
      loc    = 30'h0;
      srcv   = 36'h0;
      ctl    = 10'h000;
      none   = 10'h000;
      sel    = 6'h00;
      ena1   = 1'b0;
      ena2   = 1'b0;
      tick1  = 1'b0;
      tick2  = 1'b0;
      carry  = 1'b0;
      lchain = 1'b0;
      rchain = 1'b0;
      din    = 4'h0;
      lin    = 4'h0;
      lut    = 1'b0;
      b_op   = 1'b0;
      sum    = 1'b0;
      res    = 1'b0;
      dsrc   = 1'b0;
      nq     = 1'b0;
      tick   = 1'b0;
      aclr   = 1'b0;
      widx   = 6'h00;
      hit    = 1'b0;
      rd     = 32'h0000_0000;

      // pin inputs pass two flops before use
      s_d.sync1 = {device_wide_clear_n_in, row_clock_in, left_link_in,
                   right_link_in, routing_data_in};
      s_d.sync2 = s_q.sync1;

      // local lines: own local outputs and both neighbours
      for (int i = 0; i < 10; i++) begin
         loc[i] = s_q.outs[i][2];
      end
      loc[29:10] = {p.right, p.left};
      srcv = {loc, p.row};

      // each control picks one of 36 lines; out of range means unused
      srcs = {s_q.src_hi[29:0], s_q.src_lo[29:0]};
      for (int c = 0; c < lcc_pkg::NCTL; c++) begin
         sel = srcs[6*c +: 6];
         none[c] = (sel >= 6'(lcc_pkg::NSRC));
         ctl[c] = none[c] ? 1'b0 : srcv[sel];
      end

      // an unused enable leaves its clock running
      ena1 = none[lcc_pkg::CTL_ENA1] | ctl[lcc_pkg::CTL_ENA1];
      ena2 = none[lcc_pkg::CTL_ENA2] | ctl[lcc_pkg::CTL_ENA2];

      // cluster clocks are edge events; either may be set to the falling edge
      tick1 = (misc.fall1 ? (s_q.clk_prev[0] & ~ctl[lcc_pkg::CTL_CLK1])
                          : (~s_q.clk_prev[0] & ctl[lcc_pkg::CTL_CLK1]))
              & ena1;
      tick2 = (misc.fall2 ? (s_q.clk_prev[1] & ~ctl[lcc_pkg::CTL_CLK2])
                          : (~s_q.clk_prev[1] & ctl[lcc_pkg::CTL_CLK2]))
              & ena2;
      s_d.clk_prev = {ctl[lcc_pkg::CTL_CLK2], ctl[lcc_pkg::CTL_CLK1]};

      // first cell's carry in follows the add/subtract select
      carry = ctl[lcc_pkg::CTL_ADDNSUB];
      lchain = 1'b0;
      rchain = 1'b0;

      for (int i = 0; i < lcc_pkg::NCELL; i++) begin
         cfg = lcc_pkg::lcc_cell_cfg_s'(s_q.cfg_a[i]);
         csr = lcc_pkg::lcc_cell_src_s'(s_q.cfg_b[i]);

         for (int k = 0; k < 4; k++) begin
            din[k] = p.data[i][k];
            if (csr.use_local[k] && csr.local_sel[k] < 5'(lcc_pkg::NLOC)) begin
               din[k] = loc[csr.local_sel[k]];
            end
         end

         lin = din;
         if (cfg.pack_fb) begin
            lin[2] = s_q.q[i];
         end
         if (cfg.lut_chain) begin
            lin[3] = lchain;
         end
         lut = cfg.lut_mask[lin];

         // operand b inverted when subtracting
         b_op = din[1] ^ ctl[lcc_pkg::CTL_ADDNSUB];
         sum = din[0] ^ b_op ^ carry;
         res = cfg.arith ? sum : lut;

         dsrc = cfg.reg_chain ? rchain : res;
         unique case (cfg.ff_mode)
            lcc_pkg::LCC_FF_D:  nq = dsrc;
            lcc_pkg::LCC_FF_T:  nq = s_q.q[i] ^ dsrc;
            lcc_pkg::LCC_FF_JK: nq = (dsrc & ~s_q.q[i]) |
                                     (~din[2] & s_q.q[i]);
            lcc_pkg::LCC_FF_SR: nq = dsrc | (~din[2] & s_q.q[i]);
         endcase

         // clock and enable travel as a pair
         tick = cfg.clk_sel ? tick2 : tick1;
         if (!tick) begin
            nq = s_q.q[i];
         end else if (ctl[lcc_pkg::CTL_SCLR]) begin
            nq = 1'b0;
         end else if (ctl[lcc_pkg::CTL_SLOAD]) begin
            nq = din[3];
         end

         // level controls act without waiting for a clock event
         aclr = cfg.clr_sel ? ctl[lcc_pkg::CTL_ACLR2]
                            : ctl[lcc_pkg::CTL_ACLR1];
         if (ctl[lcc_pkg::CTL_ALOAD]) begin
            nq = din[3];
         end
         if (aclr) begin
            nq = 1'b0;
         end
         if (misc.devclr_en && !p.dev_clr_n) begin
            nq = 1'b0;
         end
         s_d.q[i] = nq;

         // outputs registered, so a bypassed result shows one cycle later
         for (int k = 0; k < 3; k++) begin
            s_d.outs[i][k] = cfg.out_reg[k] ? nq : res;
         end

         carry = (din[0] & b_op) | (carry & (din[0] ^ b_op));
         lchain = lut;
         rchain = s_q.q[i];
      end
      s_d.lut_chain = lchain;
      s_d.carry = carry;

      ////////////////////////////////////////////////////////////////////
      // wishbone slave: ack one cycle after the strobe, then dropped

      widx = wb_adr_in[7:2];
      hit = wb_cyc_in & wb_stb_in & ~s_q.ack;
      s_d.ack = hit;
      rd = 32'h0000_0000;
      if (widx < 6'(lcc_pkg::NCELL)) begin
         rd = s_q.cfg_a[widx[3:0]];
         if (hit && wb_we_in) begin
            s_d.cfg_a[widx[3:0]] = merge(s_q.cfg_a[widx[3:0]], wb_dat_in,
                                         wb_sel_in);
         end
      end else if (widx >= lcc_pkg::CFG_B_BASE[7:2] &&
                   widx < 6'(lcc_pkg::CFG_B_BASE[7:2] + lcc_pkg::NCELL)) begin
         rd = s_q.cfg_b[4'(widx - lcc_pkg::CFG_B_BASE[7:2])];
         if (hit && wb_we_in) begin
            s_d.cfg_b[4'(widx - lcc_pkg::CFG_B_BASE[7:2])] =
               merge(rd, wb_dat_in, wb_sel_in);
         end
      end else if (wb_adr_in[7:0] == lcc_pkg::SRC_LO_OFF) begin
         rd = {2'h0, s_q.src_lo[29:0]};
         if (hit && wb_we_in) begin
            s_d.src_lo = merge(rd, wb_dat_in, wb_sel_in) & 32'h3fff_ffff;
         end
      end else if (wb_adr_in[7:0] == lcc_pkg::SRC_HI_OFF) begin
         rd = {2'h0, s_q.src_hi[29:0]};
         if (hit && wb_we_in) begin
            s_d.src_hi = merge(rd, wb_dat_in, wb_sel_in) & 32'h3fff_ffff;
         end
      end else if (wb_adr_in[7:0] == lcc_pkg::MISC_OFF) begin
         rd = {29'h0, s_q.misc[2:0]};
         if (hit && wb_we_in) begin
            s_d.misc = merge(rd, wb_dat_in, wb_sel_in) & 32'h0000_0007;
         end
      end else if (wb_adr_in[7:0] == lcc_pkg::STAT_OFF) begin
         rd = {22'h0, s_q.q};
      end
      if (ADR_W > 8 && wb_adr_in[ADR_W-1:0] >= ADR_W'(256)) begin
         rd = 32'h0000_0000;
      end
      s_d.dat = (hit && !wb_we_in) ? rd : 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q <= '0;
         s_q.sync1.dev_clr_n <= 1'b1;
         s_q.sync2.dev_clr_n <= 1'b1;
         s_q.cfg_a <= {10{lcc_pkg::CFG_RESET}};
         s_q.cfg_b <= {10{lcc_pkg::CFG_RESET}};
         s_q.src_lo <= lcc_pkg::SRC_RESET;
         s_q.src_hi <= lcc_pkg::SRC_RESET;
         s_q.misc <= lcc_pkg::MISC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_out    = s_q.dat;
   assign wb_ack_out    = s_q.ack;
   assign cell_out_out  = s_q.outs;
   assign lut_chain_out = s_q.lut_chain;
   assign reg_chain_out = s_q.q[9];
   assign carry_out     = s_q.carry;

endmodule // lcc_cluster

`default_nettype wire

// ===== test/lcc_cluster_props.sv
// concurrent checks on the logic cluster bus and register behaviour
`timescale 1ns/1ps
`default_nettype none
module lcc_cluster_props #(
   parameter int ADR_W = 8
) (
   input wire logic             mclk_in,
   input wire logic             reset_in,
   input wire logic             wb_cyc_in,
   input wire logic             wb_stb_in,
   input wire logic             wb_we_in,
   input wire logic [ADR_W-1:0] wb_adr_in,
   input wire logic [3:0]       wb_sel_in,
   input wire logic [31:0]      wb_dat_in,
   input wire logic [31:0]      wb_dat_out,
   input wire logic             wb_ack_out,
   input wire logic             device_wide_clear_n_in,
   input wire logic             reg_chain_out
);
   logic        req;
   logic        wr;
   logic [31:0] cfg0_q;
   logic [31:0] misc_q;
   assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr  = req && wb_we_in;
   // shadow copies of cell 0 config and misc, lane by lane
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cfg0_q <= lcc_pkg::CFG_RESET;
         misc_q <= lcc_pkg::MISC_RESET;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wr && wb_sel_in[b] && wb_adr_in[7:2] == 6'h00) begin
               cfg0_q[8*b+:8] <= wb_dat_in[8*b+:8];
            end
            if (wr && wb_sel_in[b] && wb_adr_in[7:2] == 6'h22) begin
               misc_q[8*b+:8] <= wb_dat_in[8*b+:8];
            end
         end
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   a_ack_one_cycle: assert property (req |=> wb_ack_out)
      else $error("ack missing one cycle after request");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   a_ack_caused: assert property (wb_ack_out |-> $past(req))
      else $error("ack without a request");
   a_dat_quiet: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
      else $error("read data outside ack cycle");
   a_unmapped_zero: assert property (wb_ack_out && !wb_we_in &&
      wb_adr_in[7:0] >= 8'h90 |-> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_readback: assert property (
      wb_ack_out && !wb_we_in && wb_adr_in[7:2] == 6'h00
      |-> wb_dat_out[26:0] == cfg0_q[26:0])
      else $error("cell config readback wrong");
   a_misc_readback: assert property (
      wb_ack_out && !wb_we_in && wb_adr_in[7:2] == 6'h22
      |-> wb_dat_out[2:0] == misc_q[2:0])
      else $error("edge and clear control readback wrong");
   a_devclr_wins: assert property (
      (misc_q[2] && !device_wide_clear_n_in) [*6] |-> !reg_chain_out)
      else $error("register survives device clear");
   c_write: cover property (wr);
   c_cfg_read: cover property (wb_ack_out && wb_adr_in[7:2] == 6'h00);
   c_devclr: cover property (misc_q[2] && !device_wide_clear_n_in);
endmodule // lcc_cluster_props
bind lcc_cluster lcc_cluster_props #(.ADR_W(ADR_W)) u_props (
   .mclk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
   .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
   .device_wide_clear_n_in, .reg_chain_out);
`default_nettype wire

// ===== test/lcc_fabric_model.sv
// neighbouring clusters and routing fabric around the cluster
`timescale 1ns/1ps
`default_nettype none
module lcc_fabric_model (
   input  wire logic            mclk_in,
   input  wire logic            reset_in,
   input  wire logic [5:0]      row_req_in,
   input  wire logic [9:0][3:0] data_req_in,
   output var  logic [5:0]      row_clock_out,
   output var  logic [9:0]      left_link_out,
   output var  logic [9:0]      right_link_out,
   output var  logic [9:0][3:0] routing_data_out
);
   ////////////////////////////////////////
   // neighbours keep toggling so an unused local line never looks settled
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         row_clock_out    <= 6'h00;
         left_link_out    <= 10'h155;
         right_link_out   <= 10'h2aa;
         routing_data_out <= '0;
      end else begin
         row_clock_out    <= row_req_in;
         left_link_out    <= {left_link_out[8:0], ~left_link_out[9]};
         right_link_out   <= ~right_link_out;
         routing_data_out <= data_req_in;
      end
   end
endmodule // lcc_fabric_model
`default_nettype wire

// ===== test/lcc_cluster_tb.sv
// self-checking bench for the logic cluster
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module lcc_cluster_tb;
   logic            mclk_in = 1'b0;
   logic            reset_in = 1'b1;
   logic            cyc = 1'b0;
   logic            stb = 1'b0;
   logic            we = 1'b0;
   logic [7:0]      adr = 8'h00;
   logic [3:0]      sel = 4'hf;
   logic [31:0]     wdat = 32'h0;
   logic [5:0]      row = 6'h00;
   logic [9:0][3:0] data = '0;
   logic            clr_n = 1'b1;
   logic [31:0]     rdat, seed, r, wv;
   logic            ack, reg_chain, carry, q, v, s, lut_ch;
   logic [5:0]      row_w;
   logic [9:0]      left_w, right_w, a, b, sum, ev;
   logic [9:0][3:0] data_w;
   logic [9:0][2:0] cell_out;
   int              checked = 0;
   int              miscompares = 0;
   int              cycles = 0;
   lcc_fabric_model u_fabric (.mclk_in(mclk_in), .reset_in(reset_in),
      .row_req_in(row), .data_req_in(data), .row_clock_out(row_w),
      .left_link_out(left_w), .right_link_out(right_w),
      .routing_data_out(data_w));
   lcc_cluster #(.ADR_W(8)) u_dut (.mclk_in(mclk_in), .reset_in(reset_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .row_clock_in(row_w), .left_link_in(left_w),
      .right_link_in(right_w), .routing_data_in(data_w),
      .device_wide_clear_n_in(clr_n), .cell_out_out(cell_out),
      .lut_chain_out(lut_ch), .reg_chain_out(reg_chain), .carry_out(carry));
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   ////////////////////////////////////////
   function automatic logic [10:0] add_exp(input logic [9:0] x,
      input logic [9:0] y, input logic m);
      return {1'b0, x} + {1'b0, m ? ~y : y} + 11'(m);
   endfunction
   task automatic bus(input logic w, input logic [7:0] ad,
      input logic [31:0] d, output logic [31:0] rd);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      do @(posedge mclk_in); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic pulse(input int n);
      row[n] <= 1'b1;
      repeat (4) @(posedge mclk_in);
      row[n] <= 1'b0;
      repeat (4) @(posedge mclk_in);
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   ////////////////////////////////////////
   initial begin
      seed = 32'hed8a9449;
      repeat (20) @(posedge mclk_in);
      reset_in <= 1'b0;
      @(posedge mclk_in);
      for (int i = 0; i < 10; i++) begin
         bus(1'b0, 8'(4*i), 32'h0, r);
         `CHK(r, lcc_pkg::CFG_RESET)
      end
      bus(1'b0, lcc_pkg::SRC_HI_OFF, 32'h0, r);
      `CHK(r, lcc_pkg::SRC_RESET)
      bus(1'b1, 8'ha0, 32'hffff_ffff, r);
      bus(1'b0, 8'ha0, 32'h0, r);
      `CHK(r, 32'h0)
      for (int i = 0; i < 10; i++) begin
         // own copy: the read call reloads the bus data lines
         wv = $random(seed);
         bus(1'b1, 8'(4*i), wv, r);
         bus(1'b0, 8'(4*i), 32'h0, r);
         `CHK(r[26:0], wv[26:0])
      end
      $display("test registers done");
      bus(1'b1, 8'h00, 32'h0010_aaaa, r); // D, out0 registered, table in0
      bus(1'b1, 8'h40, 32'h0, r);
      bus(1'b1, lcc_pkg::SRC_LO_OFF, 32'h3ffc_1fc0, r); // clk1 row0, ena row1
      q = 1'b0;
      for (int k = 0; k < 6; k++) begin
         v = 1'($random(seed));
         data[0][0] <= v;
         row[1] <= k[0];
         @(posedge mclk_in);
         pulse(0);
         if (k[0]) begin
            q = v;
         end
         `CHK(cell_out[0][0], q)
         `CHK(cell_out[0][1], v)
         `CHK(cell_out[0][2], v)
      end
      $display("test clock enable done");
      bus(1'b1, lcc_pkg::SRC_LO_OFF, 32'h03fc_1fc0, r); // aclr1 row3
      bus(1'b1, lcc_pkg::SRC_HI_OFF, 32'h3ffc_2fff, r); // aload row2
      for (int k = 0; k < 5; k++) begin
         data[0][3] <= k[0] | k[2];
         row <= {2'b00, k[1], 3'b110};
         repeat (8) @(posedge mclk_in);
         `CHK(cell_out[0][0], k[1] ? 1'b0 : (k[0] | k[2]))
      end
      bus(1'b1, lcc_pkg::MISC_OFF, 32'h4, r);
      clr_n <= 1'b0;
      repeat (8) @(posedge mclk_in);
      `CHK(cell_out[0][0], 1'b0)
      bus(1'b0, lcc_pkg::STAT_OFF, 32'h0, r);
      `CHK(r[9:0], 10'h000)
      clr_n <= 1'b1;
      row <= 6'h00;
      $display("test async controls done");
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, 8'(4*i), 32'h0400_0000, r);
         bus(1'b1, 8'(8'h40 + 4*i), 32'h0, r);
      end
      bus(1'b1, lcc_pkg::SRC_LO_OFF, lcc_pkg::SRC_RESET, r);
      bus(1'b1, lcc_pkg::SRC_HI_OFF, 32'h05ff_ffff, r); // addsub row5
      for (int t = 0; t < 12; t++) begin
         a = (t == 0) ? 10'h3ff : 10'($random(seed));
         b = (t < 2) ? 10'h001 : 10'($random(seed));
         s = (t < 2) ? t[0] : 1'($random(seed));
         for (int i = 0; i < 10; i++) begin
            data[i][0] <= a[i];
            data[i][1] <= b[i];
         end
         row[5] <= s;
         repeat (8) @(posedge mclk_in);
         for (int i = 0; i < 10; i++) begin
            sum[i] = cell_out[i][0];
         end
         `CHK({carry, sum}, add_exp(a, b, s))
      end
      $display("test add subtract done");
      bus(1'b1, lcc_pkg::MISC_OFF, 32'h2, r); // clock two on falling edge
      bus(1'b1, lcc_pkg::SRC_LO_OFF, 32'h3fff_f13f, r); // clk2 row4
      bus(1'b1, lcc_pkg::SRC_HI_OFF, 32'h3f0b_f0ff, r); // sclr row3, sload row2
      for (int t = 0; t < 4; t++) begin
         // table chain parity, register chain on clock two, D or T
         for (int i = 0; i < 10; i++) begin
            bus(1'b1, 8'(4*i), t[0] ? 32'h0305_55aa : 32'h0304_55aa, r);
         end
         a = 10'($random(seed));
         b = 10'($random(seed));
         for (int i = 0; i < 10; i++) begin
            data[i][0] <= a[i];
            data[i][3] <= b[i];
         end
         row <= {2'b00, t[1], 3'b100};
         @(posedge mclk_in);
         pulse(4);
         bus(1'b0, lcc_pkg::STAT_OFF, 32'h0, r);
         ev = t[1] ? 10'h000 : b;
         `CHK(r[9:0], ev)
         `CHK(lut_ch, ^a)
         row <= 6'h00;
         @(posedge mclk_in);
         pulse(4);
         bus(1'b0, lcc_pkg::STAT_OFF, 32'h0, r);
         `CHK(r[9:0], {ev[8:0], 1'b0} ^ (t[0] ? ev : 10'h000))
         `CHK(reg_chain, ev[8] ^ (t[0] & ev[9]))
      end
      $display("test chains done");
      end_of_test();
   end
endmodule // lcc_cluster_tb
`default_nettype wire
